// *** hdl/pts_pkg.sv ***
package pts_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0]  ADDR_MODE_REQ = 8'h00;
  localparam logic [7:0]  ADDR_SEC_KEY  = 8'h04;
  localparam logic [7:0]  ADDR_SEC_CMD  = 8'h08;
  localparam logic [7:0]  ADDR_SEC_NEW  = 8'h0c;
  localparam logic [7:0]  ADDR_XFER_CMD = 8'h10;
  localparam logic [7:0]  ADDR_STATUS   = 8'h14;
  localparam logic [7:0]  ADDR_BUF_SIG  = 8'h18;
  localparam logic [7:0]  ADDR_PROG_SIG = 8'h1c;
  localparam logic [7:0]  ADDR_PASSWORD = 8'h20;

  // ==========================================================
  // Field positions
  localparam int REMOTE_BIT   = 8;
  localparam int INDEXED_BIT  = 16;
  localparam int XCODE_LSB    = 8;

  // ==========================================================
  // Mode request codes
  localparam logic [3:0] MODE_COMP0 = 4'h0;
  localparam logic [3:0] MODE_TEL5  = 4'h5;
  localparam logic [3:0] MODE_COMP6 = 4'h6;
  localparam logic [3:0] MODE_ALLOC = 4'ha;
  localparam logic [3:0] MODE_SEC   = 4'hc;
  localparam logic [3:0] MODE_XFER  = 4'hd;
  localparam logic [3:0] MODE_MCLR  = 4'he;

  // ==========================================================
  // Transfer commands, control bytes, error codes
  localparam logic [7:0]  CMD_SEND   = 8'h01;
  localparam logic [7:0]  CMD_RECV   = 8'h02;
  localparam logic [7:0]  CMD_SMOD   = 8'h47;
  localparam logic [7:0]  CH_DISCARD = 8'h02;
  localparam logic [7:0]  CH_SIG     = 8'h03;
  localparam logic [7:0]  CH_LOAD    = 8'h04;
  localparam logic [7:0]  CH_EXIT    = 8'h05;
  localparam logic [7:0]  CH_CR      = 8'h0d;
  localparam logic [7:0]  CH_LF      = 8'h0a;
  localparam logic [7:0]  CH_SEMI    = 8'h3b;
  localparam logic [7:0]  CH_MODE    = 8'h4d;
  localparam logic [7:0]  ERR_UNCORR = 8'h62;
  localparam logic [7:0]  ERR_WRONG  = 8'h63;
  localparam logic [15:0] PW_RESET   = 16'h0000;
  localparam logic [2:0]  BOOT_SLOT  = 3'h7;
  localparam int          BUF_DEPTH  = 256;

  // ==========================================================
  // Timing
  localparam longint CLK_HZ       = 10000000;
  localparam longint LOAD_WAIT_S  = 30;
  localparam longint LOAD_WAIT_CY = LOAD_WAIT_S * CLK_HZ;
  localparam logic [31:0] BOOT_WAIT_CY = 32'h0000_0004;

  typedef enum logic [1:0] {
    SM_SAVE,
    SM_LOAD,
    SM_ERASE
  } sm_op_t;
endpackage

// *** hdl/program_transfer_security.sv ***
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// - Security blocks keypad edit and allocation modes
// - Security blocks remote programming, transfer, clear
// - Password folded into program signature
// - Password gate before command window when protected
// - Window code 00 disables, 01 keeps protection
// - Reset password zero means security off
// - Compile entry re-enables unless password zero
// - Indexed password blocks edit, allows password change
// - Transfer mode suspends tables and printer output
// - Commands 1 send, 2 receive, 71 module
// - Keypad rate codes 0 to 3
// - Module codes 1X save, 2X load, 3X erase
// - Completion state refuses commands until reentry
// - Compile before save when not compiled
// - Load erases all data storage
// - Load timeout gives wrong file, errors uncorrectable
// - Remote commands reuse link rate immediately
// - Listing ends with two 0x05 bytes
// - Semicolon discards rest of line
// - Doubled control bytes discard, signature, load, exit
// - Buffer held until load or exit pair
// - Boot loads module slot 8 and compiles
module program_transfer_security
  import pts_pkg::*;
#(
  parameter longint LOAD_WAIT_CYCLES = LOAD_WAIT_CY
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_err,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_data,
  input  wire logic        i_tx_ready,
  input  wire logic [1:0]  i_link_rate,
  output logic      [1:0]  o_line_rate,
  output logic             o_sec_active,
  output logic             o_table_suspend,
  output logic             o_printer_suspend,
  output logic             o_erase_storage,
  output logic             o_editor_load,
  output logic             o_compile_req,
  input  wire logic        i_compile_done,
  output logic             o_sm_start,
  output logic      [1:0]  o_sm_op,
  output logic      [2:0]  o_sm_slot,
  input  wire logic        i_sm_done,
  input  wire logic        i_sm_err,
  input  wire logic        i_sm_present
);

  typedef enum logic [1:0] {
    SEC_IDLE,
    SEC_KEY,
    SEC_WIN1,
    SEC_WIN2
  } sec_t;

  typedef enum logic [3:0] {
    X_BOOT,
    X_OFF,
    X_CMD,
    X_COMPILE,
    X_SEND,
    X_END1,
    X_END2,
    X_RECV,
    X_SIG_LO,
    X_SM,
    X_BOOT_COMP,
    X_DONE
  } xfer_t;

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    sec_t        sec;
    logic [15:0] pw;
    logic        temp_dis;
    logic        idx_lock;
    logic        granted;
    xfer_t       xs;
    logic        compiled;
    logic [7:0]  err;
    logic [1:0]  rate;
    logic [15:0] sig;
    logic [7:0]  wptr;
    logic [7:0]  rptr;
    logic [7:0]  pend_ch;
    logic        in_comment;
    logic        seen_first;
    logic        got_data;
    logic [31:0] wait_cnt;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        erase;
    logic        ed_load;
    logic        comp_req;
    logic        sm_start;
    logic [1:0]  sm_op;
    logic [2:0]  sm_slot;
    logic [2:0]  pres_sync;
    logic        pres;
    logic        xfer_remote;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic       buf_we;
  logic [7:0] buf_wdata;

  function automatic logic [15:0] sig_step(input logic [15:0] s, input logic [7:0] b);
    sig_step = {s[14:0], s[15]} + {8'h00, b};
  endfunction

  function automatic logic [31:0] reg_read(input state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      ADDR_STATUS:   r = {s.err, 5'h00, 4'(s.xs), 1'b0, s.compiled, s.granted,
                          (s.pw != PW_RESET) && !s.temp_dis, 5'h00, 2'(s.sec),
                          s.rate, s.idx_lock, s.temp_dis};
      ADDR_BUF_SIG:  r = {16'h0000, s.sig};
      ADDR_PROG_SIG: r = {16'h0000, sig_step(s.sig, s.pw[15:8]) ^ {8'h00, s.pw[7:0]}};
      ADDR_PASSWORD: r = (s.sec == SEC_WIN2) ? {16'h0000, s.pw} : 32'h0000_0000;
      default:       r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic        active;
    logic        wr;
    logic [31:0] wd;
    logic [3:0]  mode;
    logic        remote;
    logic        ok;
    logic [7:0]  code;
    logic        rx_take;
    s_d       = s_q;
    buf_we    = 1'b0;
    buf_wdata = i_rx_data;
    active    = (s_q.pw != PW_RESET) && !s_q.temp_dis;
    wr        = s_q.wr_pend;
    wd        = i_hwdata;
    mode      = wd[3:0];
    remote    = wd[REMOTE_BIT];
    ok        = 1'b1;
    code      = wd[XCODE_LSB +: 8];
    rx_take   = 1'b0;
    s_d.erase    = 1'b0;
    s_d.ed_load  = 1'b0;
    s_d.comp_req = 1'b0;
    s_d.sm_start = 1'b0;
    s_d.pres_sync = {s_q.pres_sync[1:0], i_sm_present};
    if (s_q.pres_sync[2] == s_q.pres_sync[1]) begin
      s_d.pres = s_q.pres_sync[2];
    end

    // Bus: address phase captured, write applied in data phase
    s_d.wr_pend = i_hsel && i_hready && i_htrans[1] && i_hwrite;
    s_d.wr_addr = i_haddr[7:0];
    if (i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
      s_d.rdata = reg_read(s_q, i_haddr[7:0]);
    end

    if (s_q.tx_valid && i_tx_ready) begin
      s_d.tx_valid = 1'b0;
    end

    // Mode entry arbitration
    if (wr && s_q.wr_addr == ADDR_MODE_REQ) begin
      if (!remote) begin
        if ((mode >= 4'h1 && mode <= 4'h4) || mode == MODE_ALLOC) begin
          ok = !active && !s_q.idx_lock;
        end
      end else begin
        if ((mode >= 4'h1 && mode <= MODE_TEL5) || mode == MODE_XFER || mode == MODE_MCLR) begin
          ok = !active;
        end
      end
      s_d.granted = ok;
      if (ok) begin
        s_d.sec = SEC_IDLE;
        if ((mode == MODE_COMP0 || mode == MODE_COMP6) && s_q.pw != PW_RESET) begin
          s_d.temp_dis = 1'b0;
        end
        if (mode == MODE_SEC) begin
          s_d.sec = active ? SEC_KEY : SEC_WIN1;
        end
        if (mode == MODE_XFER) begin
          s_d.xs  = X_CMD;
          s_d.err = 8'h00;
          s_d.xfer_remote = remote;
        end else if (s_q.xs != X_BOOT && s_q.xs != X_BOOT_COMP) begin
          s_d.xs = X_OFF;
        end
      end
    end

    // Security windows
    if (wr && s_q.wr_addr == ADDR_SEC_KEY && s_q.sec == SEC_KEY) begin
      s_d.sec = (wd[15:0] == s_q.pw) ? SEC_WIN1 : SEC_IDLE;
      if (wd[15:0] == s_q.pw) begin
        s_d.idx_lock = wd[INDEXED_BIT];
      end
    end
    if (wr && s_q.wr_addr == ADDR_SEC_CMD && s_q.sec == SEC_WIN1) begin
      if (wd[7:0] == 8'h00) begin
        s_d.temp_dis = 1'b1;
        s_d.sec      = SEC_WIN2;
      end else if (wd[7:0] == 8'h01) begin
        s_d.sec = SEC_WIN2;
      end
    end
    if (wr && s_q.wr_addr == ADDR_SEC_NEW && s_q.sec == SEC_WIN2) begin
      s_d.pw       = wd[15:0];
      s_d.compiled = 1'b0;
      s_d.sec      = SEC_WIN1;
    end

    // Transfer machine
    case (s_q.xs)
      X_BOOT: begin
        // Boot from module slot 8
        // Wait until the synchroniser holds the settled pin level
        s_d.wait_cnt = s_q.wait_cnt + 32'h0000_0001;
        if (s_q.wait_cnt >= BOOT_WAIT_CY && s_q.pres) begin
          s_d.sm_start = 1'b1;
          s_d.sm_op    = 2'(SM_LOAD);
          s_d.sm_slot  = BOOT_SLOT;
          s_d.erase    = 1'b1;
          s_d.xs       = X_BOOT_COMP;
        end else if (s_q.wait_cnt >= BOOT_WAIT_CY) begin
          s_d.xs = X_OFF;
        end
      end
      X_BOOT_COMP: begin
        if (i_sm_done) begin
          s_d.comp_req = !i_sm_err;
          s_d.xs       = X_OFF;
        end
      end
      X_CMD: begin
        if (wr && s_q.wr_addr == ADDR_XFER_CMD) begin
          if ((wd[7:0] == CMD_SEND || wd[7:0] == CMD_RECV) && (s_q.xfer_remote || code < 8'h04)) begin
            s_d.rate     = s_q.xfer_remote ? i_link_rate : code[1:0];
            s_d.wait_cnt = 32'h0000_0000;
            s_d.rptr     = 8'h00;
            if (wd[7:0] == CMD_SEND) begin
              s_d.comp_req = !s_q.compiled;
              s_d.xs       = s_q.compiled ? X_SEND : X_COMPILE;
            end else begin
              s_d.erase      = 1'b1;
              s_d.xs         = X_RECV;
              s_d.seen_first = 1'b0;
              s_d.got_data   = 1'b0;
              s_d.in_comment = 1'b0;
              s_d.pend_ch    = 8'h00;
            end
          end else if (wd[7:0] == CMD_SMOD && code[3:0] >= 4'h1 && code[3:0] <= 4'h8
                       && code[7:4] >= 4'h1 && code[7:4] <= 4'h3) begin
            s_d.sm_op    = 2'(code[7:4] - 4'h1);
            s_d.sm_slot  = 3'(code[3:0] - 4'h1);
            s_d.sm_start = (code[7:4] != 4'h1) || s_q.compiled;
            s_d.comp_req = (code[7:4] == 4'h1) && !s_q.compiled;
            s_d.erase    = code[7:4] == 4'h2;
            s_d.wait_cnt = 32'h0000_0000;
            s_d.xs       = X_SM;
          end
        end
      end
      X_COMPILE: begin
        if (i_compile_done) begin
          s_d.xs = X_SEND;
        end
      end
      X_SEND: begin
        if (!s_q.tx_valid || i_tx_ready) begin
          if (s_q.rptr == s_q.wptr) begin
            s_d.xs = X_END1;
          end else begin
            s_d.tx_valid = 1'b1;
            s_d.tx_data  = buf_mem[s_q.rptr];
            s_d.rptr     = s_q.rptr + 8'h01;
          end
        end
      end
      X_END1, X_END2: begin
        if (!s_q.tx_valid || i_tx_ready) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data  = CH_EXIT;
          s_d.xs       = (s_q.xs == X_END1) ? X_END2 : X_DONE;
        end
      end
      X_SIG_LO: begin
        if (!s_q.tx_valid || i_tx_ready) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data  = s_q.sig[7:0];
          s_d.xs       = X_RECV;
        end
      end
      X_RECV: begin
        s_d.wait_cnt = s_q.wait_cnt + 32'h0000_0001;
        if (!s_q.got_data && {32'h0, s_q.wait_cnt} >= 64'(LOAD_WAIT_CYCLES - 1)) begin
          s_d.err = ERR_WRONG;
          s_d.xs  = X_DONE;
        end else if (i_rx_valid && i_rx_err) begin
          s_d.err = ERR_UNCORR;
          s_d.xs  = X_DONE;
        end else if (i_rx_valid && (!s_q.tx_valid || !(s_q.pend_ch == CH_SIG && i_rx_data == CH_SIG))) begin
          rx_take    = 1'b1;
          s_d.got_data = 1'b1;
        end
        if (rx_take) begin
          if (i_rx_data >= CH_DISCARD && i_rx_data <= CH_EXIT) begin
            s_d.pend_ch = (s_q.pend_ch == i_rx_data) ? 8'h00 : i_rx_data;
            if (s_q.pend_ch == i_rx_data) begin
              case (i_rx_data)
                CH_DISCARD: begin
                  s_d.wptr = 8'h00;
                  s_d.sig  = 16'h0000;
                end
                CH_SIG: begin
                  s_d.tx_valid = 1'b1;
                  s_d.tx_data  = s_q.sig[15:8];
                  s_d.xs       = X_SIG_LO;
                end
                CH_LOAD: begin
                  s_d.ed_load  = 1'b1;
                  s_d.compiled = 1'b0;
                  s_d.sig      = 16'h0000;
                end
                default: begin
                  s_d.comp_req = 1'b1;
                  s_d.compiled = 1'b0;
                  s_d.xs       = X_DONE;
                end
              endcase
            end
          end else begin
            s_d.pend_ch = 8'h00;
            if (i_rx_data == CH_CR || i_rx_data == CH_LF) begin
              s_d.in_comment = 1'b0;
            end else if (i_rx_data == CH_SEMI || s_q.in_comment) begin
              s_d.in_comment = 1'b1;
            end else if (!s_q.seen_first && i_rx_data != CH_MODE) begin
              s_d.err = ERR_WRONG;
              s_d.xs  = X_DONE;
            end
            if (!(i_rx_data == CH_SEMI || s_q.in_comment) &&
                (s_q.seen_first || i_rx_data == CH_MODE || i_rx_data == CH_CR || i_rx_data == CH_LF)) begin
              s_d.seen_first = s_q.seen_first || i_rx_data == CH_MODE;
              buf_we   = s_q.wptr != 8'hff;
              s_d.wptr = (s_q.wptr != 8'hff) ? s_q.wptr + 8'h01 : s_q.wptr;
              s_d.sig  = sig_step(s_q.sig, i_rx_data);
            end
          end
        end
      end
      X_SM: begin
        if (s_q.sm_op == 2'(SM_SAVE) && !s_q.sm_start && !s_q.compiled) begin
          s_d.sm_start = i_compile_done;
        end else if (i_sm_done) begin
          s_d.err      = (i_sm_err && s_q.sm_op == 2'(SM_LOAD)) ? ERR_WRONG : 8'h00;
          s_d.comp_req = !i_sm_err && s_q.sm_op == 2'(SM_LOAD);
          s_d.xs       = X_DONE;
        end else if (s_q.sm_op == 2'(SM_LOAD)) begin
          s_d.wait_cnt = s_q.wait_cnt + 32'h0000_0001;
          if ({32'h0, s_q.wait_cnt} >= 64'(LOAD_WAIT_CYCLES - 1)) begin
            s_d.err = ERR_WRONG;
            s_d.xs  = X_DONE;
          end
        end
      end
      X_OFF, X_DONE: begin
      end
      default: begin
        s_d.xs = X_OFF;
      end
    endcase
    // Compile completion set wins over a same-cycle clear
    if (i_compile_done) begin
      s_d.compiled = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s_q     <= '0;
      s_q.pw  <= PW_RESET;
      s_q.xs  <= X_BOOT;
      s_q.sec <= SEC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (buf_we) begin
      buf_mem[s_q.wptr] <= buf_wdata;
    end
  end

  // ==========================================================
  // Outputs
  assign o_hrdata          = s_q.rdata;
  assign o_hreadyout       = 1'b1;
  assign o_hresp           = 1'b0;
  assign o_tx_valid        = s_q.tx_valid;
  assign o_tx_data         = s_q.tx_data;
  assign o_line_rate       = s_q.rate;
  assign o_sec_active      = (s_q.pw != PW_RESET) && !s_q.temp_dis;
  assign o_table_suspend   = s_q.xs != X_OFF;
  assign o_printer_suspend = s_q.xs != X_OFF;
  assign o_erase_storage   = s_q.erase;
  assign o_editor_load     = s_q.ed_load;
  assign o_compile_req     = s_q.comp_req;
  assign o_sm_start        = s_q.sm_start;
  assign o_sm_op           = s_q.sm_op;
  assign o_sm_slot         = s_q.sm_slot;

endmodule // program_transfer_security

// *** bench/pts_partner.sv ***
`timescale 1ns/1ps
module pts_partner (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_present,
  input  wire logic i_sm_start,
  input  wire logic i_compile_req,
  output logic      o_sm_present,
  output logic      o_sm_done,
  output logic      o_sm_err,
  output logic      o_compile_done,
  output logic      o_tx_ready
);
  logic [3:0] sm_q;
  logic [2:0] cp_q;
  logic       ph_q;
  // ====================
  // Module and compiler answers
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sm_q <= 4'h0;
      cp_q <= 3'h0;
      ph_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      sm_q <= i_sm_start ? 4'h6 : sm_q - {3'h0, sm_q != 4'h0};
      cp_q <= i_compile_req ? 3'h3 : cp_q - {2'h0, cp_q != 3'h0};
    end
  end
  assign o_sm_present   = i_present;
  assign o_sm_done      = sm_q == 4'h1;
  assign o_sm_err       = 1'b0;
  assign o_compile_done = cp_q == 3'h1;
  assign o_tx_ready     = ph_q;
endmodule // pts_partner

// *** bench/pts_chk.sv ***
`timescale 1ns/1ps
module pts_chk (
  input logic       i_clk_sys,
  input logic       i_rst_n,
  input logic       o_hreadyout,
  input logic       o_hresp,
  input logic       o_tx_valid,
  input logic [7:0] o_tx_data,
  input logic       i_tx_ready,
  input logic [1:0] o_line_rate,
  input logic       o_sec_active,
  input logic       o_table_suspend,
  input logic       o_printer_suspend,
  input logic       o_erase_storage,
  input logic       o_editor_load,
  input logic       o_compile_req,
  input logic       o_sm_start,
  input logic [1:0] o_sm_op
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // ====================
  // Sequences
  sequence s_tx_stall;
    o_tx_valid && !i_tx_ready;
  endsequence
  sequence s_in_xfer;
    o_table_suspend && o_printer_suspend;
  endsequence
  // ====================
  // Assertions
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not okay");
  a_suspend_pair: assert property (o_table_suspend == o_printer_suspend)
    else $error("suspend outputs differ");
  a_tx_hold: assert property (s_tx_stall |=> o_tx_valid && $stable(o_tx_data))
    else $error("tx byte changed before accept");
  a_tx_in_xfer: assert property (o_tx_valid |-> o_table_suspend)
    else $error("tx outside transfer");
  a_sm_op_legal: assert property (o_sm_start |-> o_sm_op != 2'h3 && o_table_suspend)
    else $error("bad module operation");
  a_erase_pulse: assert property (o_erase_storage |-> s_in_xfer ##1 !o_erase_storage)
    else $error("erase pulse wrong");
  a_load_pulse: assert property (o_editor_load |-> s_in_xfer ##1 !o_editor_load)
    else $error("editor load pulse wrong");
  a_compile_pulse: assert property (o_compile_req |=> !o_compile_req)
    else $error("compile request too long");
  a_boot_state: assert property ($rose(i_rst_n) |-> o_table_suspend && !o_sec_active && !o_tx_valid)
    else $error("wrong state after reset");
  a_rate_frozen: assert property ($changed(o_line_rate) |-> o_table_suspend)
    else $error("rate changed outside transfer");
endmodule // pts_chk

bind program_transfer_security pts_chk u_pts_chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready), .o_line_rate(o_line_rate),
  .o_sec_active(o_sec_active), .o_table_suspend(o_table_suspend), .o_printer_suspend(o_printer_suspend),
  .o_erase_storage(o_erase_storage), .o_editor_load(o_editor_load), .o_compile_req(o_compile_req),
  .o_sm_start(o_sm_start), .o_sm_op(o_sm_op)
);

// *** bench/tb_program_transfer_security.sv ***
`timescale 1ns/1ps
module tb_program_transfer_security;
  import pts_pkg::*;
  localparam int LIM = 3000;
  logic        clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, pres = 1'b1;
  logic        rx_v = 1'b0, rx_e = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, s;
  logic [1:0]  htrans = 2'h0, link_rate = 2'h0, line_rate, sm_op, op_q;
  logic [7:0]  rx_d = 8'h0, tx_d;
  logic [2:0]  sm_slot, slot_q;
  logic [15:0] txl = 16'h0;
  logic        hrdy, hresp, tx_v, tx_rdy, sec, tsus, psus, erase, eload, creq, cdone;
  logic        sm_start, sm_done, sm_err, present;
  logic [31:0] rq [12] = '{1, 2, 3, 4, 'ha, 'h101, 'h102, 'h103, 'h104, 'h105, 'h10d, 'h10e};
  int          err_count = 0, n_checks = 0, n_st = 0, n_er = 0, n_cp = 0, n_ed = 0, n_tx = 0, k, j, c;

  always #50 clk_sys = ~clk_sys;

  program_transfer_security #(.LOAD_WAIT_CYCLES(200)) u_program_transfer_security (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_rx_valid(rx_v), .i_rx_data(rx_d), .i_rx_err(rx_e),
    .o_tx_valid(tx_v), .o_tx_data(tx_d), .i_tx_ready(tx_rdy), .i_link_rate(link_rate),
    .o_line_rate(line_rate), .o_sec_active(sec), .o_table_suspend(tsus), .o_printer_suspend(psus),
    .o_erase_storage(erase), .o_editor_load(eload), .o_compile_req(creq), .i_compile_done(cdone),
    .o_sm_start(sm_start), .o_sm_op(sm_op), .o_sm_slot(sm_slot), .i_sm_done(sm_done),
    .i_sm_err(sm_err), .i_sm_present(present)
  );
  pts_partner u_pts_partner (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_present(pres), .i_sm_start(sm_start),
    .i_compile_req(creq), .o_sm_present(present), .o_sm_done(sm_done), .o_sm_err(sm_err),
    .o_compile_done(cdone), .o_tx_ready(tx_rdy)
  );

  // ====================
  // Output monitor
  always @(posedge clk_sys) begin
    if (sm_start) begin
      n_st <= n_st + 1;
      op_q <= sm_op;
      slot_q <= sm_slot;
    end
    if (erase) n_er <= n_er + 1;
    if (creq) n_cp <= n_cp + 1;
    if (eload) n_ed <= n_ed + 1;
    if (tx_v && tx_rdy) begin
      n_tx <= n_tx + 1;
      txl <= {txl[7:0], tx_d};
    end
  end

  // ====================
  // Tasks
  task results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task ck(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tmo(input int n);
    if (n >= LIM) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      results;
    end
  endtask
  task cyc;
    @(posedge clk_sys);
    #1;
  endtask
  task rdy;
    for (j = 0; j < LIM; j++) begin
      @(posedge clk_sys);
      if (hrdy === 1'b1) break;
    end
    tmo(j);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
    #1;
  endtask
  task cs(input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, ADDR_STATUS, 32'h0);
    ck(r & m, e);
  endtask
  task mr(input logic [31:0] d);
    bus(1'b1, ADDR_MODE_REQ, d);
  endtask
  task unlock(input logic [31:0] key);
    mr(MODE_SEC);
    bus(1'b1, ADDR_SEC_KEY, key);
  endtask
  task rx(input logic [7:0] b, input logic e = 1'b0);
    @(posedge clk_sys);
    rx_v <= 1'b1;
    rx_d <= b;
    rx_e <= e;
    @(posedge clk_sys);
    rx_v <= 1'b0;
    rx_e <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task wdone;
    for (k = 0; k < LIM; k++) begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      if ((r & 32'h78000) === 32'h58000) break;
    end
    tmo(k);
  endtask
  task rst(input logic p);
    @(posedge clk_sys);
    pres <= p;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc;
    for (k = 0; k < LIM && tsus !== 1'b0; k++) cyc;
    tmo(k);
    cyc;
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys);
    tmo(LIM);
  end

  // ====================
  // Main sequence
  initial begin
    rst(1'b1);
    ck(n_st, 1); ck(op_q, SM_LOAD); ck(slot_q, BOOT_SLOT); ck(n_cp, 1);
    ck(n_er, 1); ck(sec, 1'b0);
    rst(1'b0);
    ck(n_st, 1);
    $display("boot test done");
    mr(MODE_SEC); cs(32'h30, 32'h20);
    bus(1'b1, ADDR_SEC_CMD, 32'h1); cs(32'h30, 32'h30);
    bus(1'b0, ADDR_PASSWORD, 32'h0); ck(r, 32'h0);
    bus(1'b0, ADDR_PROG_SIG, 32'h0); s = r;
    bus(1'b1, ADDR_SEC_NEW, 32'h1234); cs(32'h30, 32'h20);
    bus(1'b0, ADDR_PROG_SIG, 32'h0); ck({31'h0, r === s}, 32'h0);
    mr(MODE_COMP0); ck(sec, 1'b1);
    for (int i = 0; i < 12; i++) begin
      mr(rq[i]); cs(32'h1000, 32'h0);
    end
    mr(MODE_TEL5); cs(32'h1000, 32'h1000);
    mr(MODE_SEC); cs(32'h30, 32'h10);
    bus(1'b1, ADDR_SEC_KEY, 32'h9999); cs(32'h30, 32'h0);
    for (int i = 0; i < 2; i++) begin
      unlock(32'h1234); bus(1'b1, ADDR_SEC_CMD, 32'h0); cs(32'h801, 32'h1);
      mr(MODE_ALLOC); cs(32'h1000, 32'h1000);
      mr(i ? MODE_COMP6 : MODE_COMP0); ck(sec, 1'b1);
    end
    unlock(32'h11234); cs(32'h2, 32'h2);
    bus(1'b1, ADDR_SEC_CMD, 32'h0); bus(1'b0, ADDR_PASSWORD, 32'h0); ck(r[15:0], 16'h1234);
    mr(MODE_ALLOC); cs(32'h1000, 32'h0);
    bus(1'b1, ADDR_SEC_NEW, 32'h0); mr(MODE_COMP0); ck(sec, 1'b0);
    $display("security test done");
    mr(MODE_XFER); bus(1'b1, ADDR_XFER_CMD, {24'h02, CMD_RECV}); ck(line_rate, 2'h2);
    ck(tsus & psus, 1'b1);
    rx(CH_MODE); rx(8'h31); rx(CH_SIG); rx(CH_SIG);
    for (k = 0; k < LIM && n_tx < 2; k++) cyc;
    tmo(k);
    ck(txl, 16'h00cb); ck(n_er, 2);
    bus(1'b0, ADDR_BUF_SIG, 32'h0); ck(r[15:0], 16'h00cb);
    rx(CH_SEMI); bus(1'b0, ADDR_BUF_SIG, 32'h0); s = r;
    rx(8'h5a); bus(1'b0, ADDR_BUF_SIG, 32'h0); ck(r, s);
    rx(CH_LF); rx(CH_DISCARD); rx(CH_DISCARD); bus(1'b0, ADDR_BUF_SIG, 32'h0); ck(r[15:0], 16'h0);
    rx(CH_MODE); rx(8'h31); rx(CH_LOAD); ck(n_ed, 0); rx(CH_LOAD); ck(n_ed, 1);
    c = n_cp;
    rx(CH_EXIT); rx(CH_EXIT); wdone; ck(n_cp, c + 1);
    bus(1'b1, ADDR_XFER_CMD, {24'h02, CMD_SEND}); repeat (20) cyc; ck(n_tx, 2);
    $display("receive test done");
    @(posedge clk_sys);
    link_rate <= 2'h3;
    mr(32'h100 | MODE_XFER); bus(1'b1, ADDR_XFER_CMD, {24'h01, CMD_SEND}); ck(line_rate, 2'h3);
    for (k = 0; k < LIM && txl !== 16'h0505; k++) cyc;
    tmo(k);
    wdone;
    $display("send test done");
    for (int i = 1; i < 4; i++) begin
      c = n_er;
      mr(MODE_XFER); bus(1'b1, ADDR_XFER_CMD, {16'h0, 4'(i), 4'(i + 5), CMD_SMOD}); wdone;
      ck(op_q, 32'(i - 1)); ck(slot_q, 32'(i + 4)); ck(n_er, 32'(c + (i == 2)));
    end
    $display("module test done");
    mr(MODE_XFER); bus(1'b1, ADDR_XFER_CMD, {24'h00, CMD_RECV}); ck(line_rate, 2'h0);
    repeat (260) cyc; cs(32'hff000000, {ERR_WRONG, 24'h0});
    mr(MODE_XFER); bus(1'b1, ADDR_XFER_CMD, {24'h03, CMD_RECV}); ck(line_rate, 2'h3);
    rx(CH_MODE, 1'b1); wdone;
    cs(32'hff000000, {ERR_UNCORR, 24'h0});
    $display("error test done");
    results;
  end
endmodule // tb_program_transfer_security
